//--- ddc_params.svh
// Register map, field positions, reset values and timing constants for DDR I/O calibration
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH
// Register byte offsets
`define DDC_CTRL_OFS 12'h000
`define DDC_INTV_OFS 12'h004
`define DDC_CODE_OFS 12'h008
`define DDC_STAT_OFS 12'h00C
// Control register fields
`define DDC_EN_BIT 0
`define DDC_DLY_LSB 8
`define DDC_DLY_MSB 14
// Code register fields
`define DDC_CP_LSB 0
`define DDC_CP_MSB 3
`define DDC_CN_LSB 8
`define DDC_CN_MSB 11
// Status register fields
`define DDC_ST_LSB 0
`define DDC_ST_MSB 1
`define DDC_DONE_LSB 8
`define DDC_DONE_MSB 15
// Reset values
`define DDC_DLY_RST 7'h00
`define DDC_EN_RST 1'h0
`define DDC_INTV_RST 16'h0000
`define DDC_CP_RST 4'h7
`define DDC_CN_RST 4'h8
// Length of one calibration sequence in sdram clock cycles
`define DDC_CAL_CYC 8'h10
// Address decode width (byte address bits)
`define DDC_ADDR_W 12
`endif

//--- ddc_pkg.sv
// Types shared by the DDR I/O calibration control
package ddc_pkg;
   // Calibration sequencer states
   typedef enum logic [1:0] {
      DDC_IDLE,
      DDC_WARMUP,
      DDC_CALIB
   } ddc_state_e;
endpackage : ddc_pkg

//--- ddc_timer.sv
// Reloading interval timer that emits one-cycle calibration pulses
`timescale 1ns/1ns
module ddc_timer #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic run,
   input wire logic [W-1:0] load,
   output logic pulse
);
   logic [W-1:0] cnt_q, cnt_d; // Remaining cycles to next pulse
   logic pulse_q, pulse_d; // Registered pulse

   // Next count: reload while stopped or on expiry, else count down
   always_comb begin
      cnt_d = cnt_q;
      pulse_d = 1'b0;
      if (!run) begin
         cnt_d = load; // No pulses while disabled
      end else if (cnt_q == '0) begin
         pulse_d = 1'b1; // Expiry fires the pulse
         cnt_d = load; // Reload so pulses recur
      end else begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // Registers, frozen while clock enable is low
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         pulse_q <= pulse_d;
      end
   end

   assign pulse = pulse_q;
endmodule : ddc_timer

//--- ddc_calib_ctrl.sv
// DDR I/O calibration control with AHB-Lite register slave
//
// Overview of operation
// - Wait programmed start-up delay before calibrating
// - Start-up delay field is seven bits
// - Calibration enable resets to zero, disabled
// - Interval count loads a pulse timer
// - Each timer pulse seen while idle starts one calibration
// - Read-only P transistor code, reset 7
// - Read-only N transistor code, reset 8
// - All counts use the sdram clock
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`include "ddc_params.svh"
module ddc_calib_ctrl
   import ddc_pkg::*;
#(
   parameter int INTV_W = 16,
   parameter int DLY_W = 7
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic CLK_EN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [3:0] PAD_P_CODE,
   input wire logic [3:0] PAD_N_CODE,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic CAL_AMP_ON,
   output logic CAL_ACTIVE,
   output logic CAL_START
);
   // Bus data phase tracking
   logic wr_pend_q, wr_pend_d; // Write data phase pending
   logic rdy_q, rdy_d; // Bus ready, low only while in reset
   logic [`DDC_ADDR_W-1:0] wr_addr_q, wr_addr_d; // Latched write address
   logic [31:0] rdata_q, rdata_d; // Registered read data
   // Software-visible configuration
   logic en_q, en_d; // Calibration enable
   logic [DLY_W-1:0] dly_q, dly_d; // Amplifier start-up delay
   logic [INTV_W-1:0] intv_q, intv_d; // Calibration interval count
   // Calibration codes from the pads
   logic [3:0] p_code_q, p_code_d;
   logic [3:0] n_code_q, n_code_d;
   logic [3:0] ps1_q, ps2_q, ps3_q; // Pad P code synchroniser
   logic [3:0] ns1_q, ns2_q, ns3_q; // Pad N code synchroniser
   // Sequencer
   ddc_state_e st_q, st_d;
   logic [DLY_W-1:0] wcnt_q, wcnt_d; // Warm-up counter
   logic [7:0] ccnt_q, ccnt_d; // Calibration length counter
   logic [7:0] cal_done_q, cal_done_d; // Completed sequence count
   logic amp_q, amp_d, act_q, act_d, start_q, start_d; // Output flops
   logic pulse; // Timer pulse
   logic take; // Address phase accepted

   // Word-aligned offset decode, used for reads and writes
   function automatic logic [`DDC_ADDR_W-1:0] word_ofs(input logic [31:0] a);
      word_ofs = {a[`DDC_ADDR_W-1:2], 2'b00};
   endfunction : word_ofs

   assign take = HSEL && HREADY && HTRANS[1];

   // Interval timer on the sdram clock
   ddc_timer #(
      .W(INTV_W)
   ) u_timer (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .ce(CLK_EN),
      .run(en_q),
      .load(intv_q),
      .pulse(pulse)
   );

   // Bus slave and configuration next state
   always_comb begin
      wr_pend_d = 1'b0;
      rdy_d = 1'b1; // Never stalls once out of reset
      wr_addr_d = wr_addr_q;
      rdata_d = rdata_q;
      en_d = en_q;
      dly_d = dly_q;
      intv_d = intv_q;
      // Write data lands one cycle after its address phase
      if (wr_pend_q) begin
         case (wr_addr_q)
            `DDC_CTRL_OFS: begin
               en_d = HWDATA[`DDC_EN_BIT];
               dly_d = HWDATA[`DDC_DLY_MSB:`DDC_DLY_LSB]; // Seven bits
            end
            `DDC_INTV_OFS: begin
               intv_d = HWDATA[INTV_W-1:0];
            end
            default: begin
               // Read-only and unmapped writes are dropped
            end
         endcase
      end
      if (take) begin
         wr_pend_d = HWRITE;
         wr_addr_d = word_ofs(HADDR);
         rdata_d = 32'h00000000; // Unmapped reads return zero
         if (!HWRITE) begin
            case (word_ofs(HADDR))
               `DDC_CTRL_OFS: begin
                  rdata_d[`DDC_EN_BIT] = en_q;
                  rdata_d[`DDC_DLY_MSB:`DDC_DLY_LSB] = dly_q;
               end
               `DDC_INTV_OFS: begin
                  rdata_d[INTV_W-1:0] = intv_q;
               end
               `DDC_CODE_OFS: begin
                  rdata_d[`DDC_CP_MSB:`DDC_CP_LSB] = p_code_q;
                  rdata_d[`DDC_CN_MSB:`DDC_CN_LSB] = n_code_q;
               end
               `DDC_STAT_OFS: begin
                  rdata_d[`DDC_ST_MSB:`DDC_ST_LSB] = st_q;
                  rdata_d[`DDC_DONE_MSB:`DDC_DONE_LSB] = cal_done_q;
               end
               default: begin
                  rdata_d = 32'h00000000;
               end
            endcase
         end
      end
   end

   // Bus and configuration registers
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_pend_q <= 1'b0;
         rdy_q <= 1'b0;
         wr_addr_q <= '0;
         rdata_q <= 32'h00000000;
         en_q <= `DDC_EN_RST; // Disabled after reset
         dly_q <= `DDC_DLY_RST;
         intv_q <= `DDC_INTV_RST;
      end else if (CLK_EN) begin
         wr_pend_q <= wr_pend_d;
         rdy_q <= rdy_d;
         wr_addr_q <= wr_addr_d;
         rdata_q <= rdata_d;
         en_q <= en_d;
         dly_q <= dly_d;
         intv_q <= intv_d;
      end
   end

   // Pad code synchronisers: three stages, accept when last two agree
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ps1_q <= `DDC_CP_RST;
         ps2_q <= `DDC_CP_RST;
         ps3_q <= `DDC_CP_RST;
         ns1_q <= `DDC_CN_RST;
         ns2_q <= `DDC_CN_RST;
         ns3_q <= `DDC_CN_RST;
      end else if (CLK_EN) begin
         ps1_q <= PAD_P_CODE;
         ps2_q <= ps1_q;
         ps3_q <= ps2_q;
         ns1_q <= PAD_N_CODE;
         ns2_q <= ns1_q;
         ns3_q <= ns2_q;
      end
   end

   // Sequencer: warm-up delay, then a fixed-length calibration
   always_comb begin
      st_d = st_q;
      wcnt_d = wcnt_q;
      ccnt_d = ccnt_q;
      cal_done_d = cal_done_q;
      p_code_d = p_code_q;
      n_code_d = n_code_q;
      amp_d = amp_q;
      act_d = 1'b0;
      start_d = 1'b0;
      case (st_q)
         DDC_IDLE: begin
            amp_d = 1'b0;
            if (pulse && en_q) begin
               st_d = DDC_WARMUP; // Pulse opens one sequence
               wcnt_d = dly_q;
               amp_d = 1'b1;
            end
         end
         DDC_WARMUP: begin
            amp_d = 1'b1;
            if (wcnt_q == '0) begin
               st_d = DDC_CALIB; // Delay elapsed
               ccnt_d = `DDC_CAL_CYC;
               start_d = 1'b1;
               act_d = 1'b1;
            end else begin
               wcnt_d = wcnt_q - 1'b1; // One sdram clock each
            end
         end
         DDC_CALIB: begin
            act_d = 1'b1;
            // Codes only change while a sequence runs
            if (ps2_q == ps3_q) begin
               p_code_d = ps3_q;
            end
            if (ns2_q == ns3_q) begin
               n_code_d = ns3_q;
            end
            if (ccnt_q == 8'h01) begin
               st_d = DDC_IDLE;
               act_d = 1'b0;
               amp_d = 1'b0;
               cal_done_d = cal_done_q + 8'h01;
            end else begin
               ccnt_d = ccnt_q - 8'h01;
            end
         end
         default: begin
            st_d = DDC_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_q <= DDC_IDLE;
         wcnt_q <= '0;
         ccnt_q <= 8'h00;
         cal_done_q <= 8'h00;
         p_code_q <= `DDC_CP_RST;
         n_code_q <= `DDC_CN_RST;
         amp_q <= 1'b0;
         act_q <= 1'b0;
         start_q <= 1'b0;
      end else if (CLK_EN) begin
         st_q <= st_d;
         wcnt_q <= wcnt_d;
         ccnt_q <= ccnt_d;
         cal_done_q <= cal_done_d;
         p_code_q <= p_code_d;
         n_code_q <= n_code_d;
         amp_q <= amp_d;
         act_q <= act_d;
         start_q <= start_d;
      end
   end

   // Zero-wait slave: ready except in reset, always OKAY
   assign HRDATA = rdata_q;
   assign HREADYOUT = rdy_q;
   assign HRESP = 1'b0;
   assign CAL_AMP_ON = amp_q;
   assign CAL_ACTIVE = act_q;
   assign CAL_START = start_q;
endmodule : ddc_calib_ctrl

//--- ddc_calib_ctrl_assertions.sv
// Concurrent checks on the bus response and calibration outputs of the DDR I/O calibration control
`timescale 1ns/1ns
module ddc_calib_ctrl_chk (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic HRESP,
   input wire logic CAL_AMP_ON,
   input wire logic CAL_ACTIVE,
   input wire logic CAL_START
);
   // All checks share the sdram clock and the async reset
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   // Eight cycles of a running sequence with the amplifier powered
   sequence s_run8;
      (CAL_ACTIVE && CAL_AMP_ON) [*8];
   endsequence
   a_resp_okay: assert property (HRESP == 1'h0) else $error("error response seen");
   a_start_pulse: assert property (CAL_START |=> !CAL_START) else $error("start too long");
   a_active_len: assert property (CAL_START |-> s_run8 ##1 s_run8 ##1 !CAL_ACTIVE)
      else $error("sequence length wrong");
   a_delay_max: assert property ($rose(CAL_AMP_ON) |-> ##[1:128] CAL_START)
      else $error("start-up delay too long");
   a_amp_hold: assert property ($rose(CAL_AMP_ON) |-> (CAL_AMP_ON && !CAL_ACTIVE) until CAL_START)
      else $error("warm-up broken");
   a_start_order: assert property (CAL_START |-> $past(CAL_AMP_ON) && !$past(CAL_ACTIVE))
      else $error("start without warm-up");
   a_amp_falls: assert property ($fell(CAL_ACTIVE) |-> !CAL_AMP_ON)
      else $error("amplifier left on");
   a_no_overlap: assert property (CAL_ACTIVE |-> CAL_AMP_ON && !(CAL_START && $past(CAL_ACTIVE)))
      else $error("sequences overlap");
endmodule : ddc_calib_ctrl_chk
bind ddc_calib_ctrl ddc_calib_ctrl_chk u_chk (.CLOCK(CLOCK), .ARST_N(ARST_N), .HRESP(HRESP),
   .CAL_AMP_ON(CAL_AMP_ON), .CAL_ACTIVE(CAL_ACTIVE), .CAL_START(CAL_START));

//--- ddc_pad_model.sv
// Behavioural pad calibration cell that feeds transistor codes back to the controller
`timescale 1ns/1ns
module ddc_pad_model (
   input wire logic clk,
   input wire logic amp_on,
   input wire logic [3:0] p_set,
   input wire logic [3:0] n_set,
   output logic [3:0] p_code,
   output logic [3:0] n_code
);
   // Garbage that changes every cycle, so unpowered pads never look settled
   logic [3:0] junk_q = 4'h0;
   always @(posedge clk) begin
      junk_q <= junk_q + 4'h5;
   end
   // Codes are only meaningful while the amplifier is powered
   assign p_code = amp_on ? p_set : junk_q;
   assign n_code = amp_on ? n_set : ~junk_q;
endmodule : ddc_pad_model

//--- ddr_io_calibration_control_test.sv
// Self-checking bench for the DDR I/O calibration control
`timescale 1ns/1ns
`include "ddc_params.svh"
module ddr_io_calibration_control_test;
   logic CLOCK, ARST_N, HSEL, HWRITE, HREADYOUT, HRESP, CAL_AMP_ON, CAL_ACTIVE, CAL_START, amp_d;
   logic CLK_EN;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [31:0] HADDR, HWDATA, HRDATA, rd;
   logic [3:0] PAD_P_CODE, PAD_N_CODE, p_set, n_set;
   logic [16:0] rnd;
   int errors, check_count, cyc, d, n, m_cnt;
   int q_amp[$];
   int q_st[$];
   ddc_calib_ctrl dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .PAD_P_CODE(PAD_P_CODE), .PAD_N_CODE(PAD_N_CODE), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .CAL_AMP_ON(CAL_AMP_ON), .CAL_ACTIVE(CAL_ACTIVE), .CAL_START(CAL_START));
   ddc_pad_model pad (.clk(CLOCK), .amp_on(CAL_AMP_ON), .p_set(p_set), .n_set(n_set),
      .p_code(PAD_P_CODE), .n_code(PAD_N_CODE));
   // Pseudo-random source
   function automatic logic [16:0] nx(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : nx
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One single AHB transfer; the slave's ready decides each phase length
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge CLOCK);
      HSEL <= 1'h1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= {20'h0, a};
      do @(posedge CLOCK); while (HREADYOUT !== 1'h1);
      HSEL <= 1'h0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge CLOCK); while (HREADYOUT !== 1'h1);
      rd = HRDATA;
   endtask : bus
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      check(rd, e);
   endtask : rdchk
   task end_sim;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   initial begin
      CLOCK = 1'h0;
      forever #5 CLOCK = ~CLOCK;
   end
   // Event log sampled mid-cycle, away from the launching edge
   always @(negedge CLOCK) begin
      cyc++;
      if (CAL_AMP_ON === 1'h1 && amp_d !== 1'h1) q_amp.push_back(cyc);
      if (CAL_START === 1'h1) q_st.push_back(cyc);
      amp_d = CAL_AMP_ON;
   end
   // Watchdog far beyond the roughly 3700 cycles the tests need
   initial begin
      repeat (20000) @(posedge CLOCK);
      errors++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim;
   end
   initial begin
      {ARST_N, HSEL, HWRITE, HTRANS, HADDR, HWDATA, p_set, n_set} = '0;
      HSIZE = 3'h2;
      CLK_EN = 1'h1;
      rnd = 17'h173F5;
      repeat (4) @(posedge CLOCK);
      ARST_N <= 1'h1;
      rdchk(`DDC_CTRL_OFS, 32'h0);
      rdchk(`DDC_INTV_OFS, 32'h0);
      rdchk(`DDC_CODE_OFS, 32'h807);
      for (int i = 0; i < 4; i++) begin
         rnd = nx(rnd);
         // Last pass programs the delay as software should: 600 ns of 10 ns cycles, plus one
         d = (i == 0) ? 0 : (i == 1) ? 127 : (i == 2) ? rnd[6:0] : 600 / 10 + 1;
         n = 160 + rnd[12:7];
         p_set <= rnd[16:13];
         n_set <= rnd[10:7];
         q_amp.delete();
         q_st.delete();
         bus(1'h1, `DDC_INTV_OFS, n);
         bus(1'h1, `DDC_CTRL_OFS, (d << 8) | 1);
         rdchk(`DDC_CTRL_OFS, (d << 8) | 1);
         for (int k = 0; k < 3000 && q_st.size() < 2; k++) @(posedge CLOCK);
         repeat (20) @(posedge CLOCK);
         check(q_st[1] - q_st[0], n + 1);
         check(q_st[0] - q_amp[0], d + 1);
         check(q_amp.size(), 2);
         m_cnt += 2;
         bus(1'h1, `DDC_CTRL_OFS, d << 8);
         rdchk(`DDC_STAT_OFS, m_cnt << 8);
         rdchk(`DDC_CODE_OFS, {20'h0, n_set, 4'h0, p_set});
         repeat (2 * n) @(posedge CLOCK);
         check(q_st.size(), 2);
         $display("test %0d done", i);
      end
      bus(1'h1, `DDC_CODE_OFS, 32'hFFFFFFFF);
      rdchk(`DDC_CODE_OFS, {20'h0, n_set, 4'h0, p_set});
      rdchk(12'h010, 32'h0);
      // Clock enable low freezes the slave, so this write must not land
      CLK_EN <= 1'h0;
      bus(1'h1, `DDC_INTV_OFS, 32'h0000BEEF);
      CLK_EN <= 1'h1;
      rdchk(`DDC_INTV_OFS, n);
      $display("test register map done");
      end_sim;
   end
endmodule : ddr_io_calibration_control_test
